/* rtl/led_dim_defs.svh */
// Constants for the LED pulse-dimming control block
`ifndef LED_DIM_DEFS_SVH
`define LED_DIM_DEFS_SVH

// Clock period at 125 MHz
`define LD_CLK_NS 8

// Dimming pulse window and shutdown delay, as printed, in ns
`define LD_PULSE_MIN_NS 500
`define LD_PULSE_MAX_NS 250000
`define LD_SHDN_NS 2500000

// Least times round up, longest times round down
`define LD_PULSE_MIN_CYC ((`LD_PULSE_MIN_NS + `LD_CLK_NS - 1) / `LD_CLK_NS)
`define LD_PULSE_MAX_CYC (`LD_PULSE_MAX_NS / `LD_CLK_NS)
`define LD_SHDN_CYC (`LD_SHDN_NS / `LD_CLK_NS)

// Brightness levels in 1/32 of full scale
`define LD_FULL_LEVEL 6'h20
`define LD_STEP_MAX 5'h1F
`define LD_STEP_RESET 5'h00

// Thermal derating in permille of full current
`define LD_DERATE_START_C 9'sh028
`define LD_DERATE_PER_C 16'h0011
`define LD_FULL_PERMILLE 16'h03E8

// Thermal shutdown trip and hysteresis in degrees C
`define LD_TSD_ON_C 9'sh0A0
`define LD_TSD_HYST_C 9'sh014

`endif

/* rtl/led_dim_pkg.sv */
// Types shared by the LED pulse-dimming control block
`default_nettype none

package led_dim_pkg;

    typedef enum logic [1:0] {
        CH_OFF = 2'b00,
        CH_ON  = 2'b01,
        CH_LOW = 2'b11
    } chan_state_t;

    typedef enum logic [1:0] {
        PUMP_OFF       = 2'b00,
        PUMP_PRECHARGE = 2'b01,
        PUMP_SOFT      = 2'b11,
        PUMP_RUN       = 2'b10
    } pump_state_t;

    typedef enum logic [1:0] {
        RATIO_1X   = 2'b00,
        RATIO_1P5X = 2'b01,
        RATIO_2X   = 2'b11
    } ratio_t;

    // Comparator results from the analog side
    typedef struct packed {
        logic minFeedbackLow;
        logic inAboveOut;
        logic inAboveTwoThirds;
        logic outPrecharged;
        logic feedbackRegulated;
    } sense_t;

    typedef struct packed {
        logic on;
        logic [4:0] step;
    } group_t;

endpackage : led_dim_pkg

`default_nettype wire

/* rtl/pulse_dim_channel.sv */
// Single-wire pulse decoder and dimming step counter for one LED group
`timescale 1ns/1ps
`default_nettype none
`include "led_dim_defs.svh"

module pulse_dim_channel #(
    parameter int MIN_CYC = `LD_PULSE_MIN_CYC,
    parameter int MAX_CYC = `LD_PULSE_MAX_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic line,
    input wire logic clear,
    output var led_dim_pkg::group_t grp
);

    localparam logic [15:0] MINC = 16'(MIN_CYC);
    localparam logic [15:0] MAXC = 16'(MAX_CYC);

    led_dim_pkg::chan_state_t state;
    logic [15:0] lowCnt;
    logic [4:0] step;
    logic on;

    wire logic longEnough = lowCnt >= MINC;
    wire logic timedOut = lowCnt >= MAXC;

    assign grp = '{on: on, step: step};

    // ************************************************************
    // Pulse decoder
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            state <= led_dim_pkg::CH_OFF;
            lowCnt <= 16'h0000;
            step <= `LD_STEP_RESET;
            on <= 1'b0;
        end else begin
            case (state)
                led_dim_pkg::CH_OFF: begin
                    if (line) begin
                        state <= led_dim_pkg::CH_ON;
                        step <= `LD_STEP_RESET;
                        on <= 1'b1;
                    end
                end
                led_dim_pkg::CH_ON: begin
                    if (!line) begin
                        state <= led_dim_pkg::CH_LOW;
                        lowCnt <= 16'h0001;
                    end
                end
                led_dim_pkg::CH_LOW: begin
                    if (line) begin
                        state <= led_dim_pkg::CH_ON;
                        // Glitches below the window are ignored
                        if (longEnough) begin
                            step <= step + 5'h01;
                        end
                    end else if (timedOut) begin
                        // Held low past the window: group disabled
                        state <= led_dim_pkg::CH_OFF;
                        step <= `LD_STEP_RESET;
                        on <= 1'b0;
                    end else begin
                        lowCnt <= lowCnt + 16'h0001;
                    end
                end
                default: begin
                    state <= led_dim_pkg::CH_OFF;
                    on <= 1'b0;
                end
            endcase
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_enable_full: assert property ($rose(on) |-> step == 5'h00)
        else $error("group enabled with nonzero step");
    a_pulse_step: assert property ((state == led_dim_pkg::CH_LOW && line
        && longEnough && !clear && step != 5'h1F)
        |=> step == $past(step) + 5'h01)
        else $error("valid pulse did not lower current one step");
    a_short_ignored: assert property ((state == led_dim_pkg::CH_LOW && line
        && !longEnough && !clear) |=> $stable(step))
        else $error("short glitch changed the step");
    a_step_wrap: assert property ((state == led_dim_pkg::CH_LOW && line
        && longEnough && !clear && step == 5'h1F) |=> step == 5'h00)
        else $error("32nd pulse did not return to full scale");
    a_clear_step: assert property (clear |=> !on && step == 5'h00)
        else $error("clear did not reset the group");

endmodule : pulse_dim_channel
`default_nettype wire

/* rtl/led_pulse_dimming_control.sv */
// Enable decoding, shutdown, charge-pump ratio and thermal control
`timescale 1ns/1ps
`default_nettype none
`include "led_dim_defs.svh"

// Overview of operation
// - A group enabled from off starts at full brightness, step zero.
// - Each low pulse of 500ns to 250us lowers current by 1/32.
// - After the 31st pulse the group runs at 1/32 of full scale.
// - The 32nd pulse wraps the group back to full scale.
// - All enables low for 2.5ms puts the device in shutdown.
// - Main current is zero once main enables are held low past 250us, full when enabled from off.
// - The flash enable alone switches the flash pair on and off.
// - In 1x the pump moves to 1.5x when feedback drops below 100mV.
// - In 1.5x the pump returns to 1x once input exceeds output.
// - In 1.5x the pump moves to 2x when feedback drops below 100mV.
// - In 2x the pump returns to 1.5x once input exceeds 2/3 output.
// - After precharge a ratio is chosen; 1x ends soft-start at once.
// - With 1.5x or 2x, soft-start lasts until feedback regulates.
// - Current limit falls 1.7% per degree above +40C.
// - Shutdown at +160C, restart after cooling by 20C.
module led_pulse_dimming_control #(
    parameter int PULSE_MAX_CYC = `LD_PULSE_MAX_CYC,
    parameter int SHDN_CYC = `LD_SHDN_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic main_enable_a,
    input wire logic main_enable_b,
    input wire logic flash_enable,
    input wire led_dim_pkg::sense_t sense,
    input wire logic signed [8:0] dieTemp,
    output var led_dim_pkg::group_t mainGroup,
    output var led_dim_pkg::group_t flashGroup,
    output logic [5:0] mainLevel,
    output logic [5:0] flashLevel,
    output logic [9:0] currentLimit,
    output var led_dim_pkg::ratio_t ratio,
    output var led_dim_pkg::pump_state_t pumpState,
    output logic softStart,
    output logic shutdown,
    output logic isolate,
    output logic outPulldown,
    output logic thermalOff
);

    localparam logic [19:0] SHDN_C = 20'(SHDN_CYC);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [5:0] levelOf(input led_dim_pkg::group_t g,
                                           input logic hot);
        if (!g.on || hot) begin
            return 6'h00;
        end
        return `LD_FULL_LEVEL - {1'b0, g.step};
    endfunction : levelOf

    function automatic logic [9:0] derateLimit(input logic signed [8:0] t);
        logic [15:0] over;
        logic [15:0] drop;
        over = 16'h0000;
        drop = 16'h0000;
        if (t <= `LD_DERATE_START_C) begin
            return 10'(`LD_FULL_PERMILLE);
        end
        over = {7'h00, 9'(t - `LD_DERATE_START_C)};
        drop = 16'(over * `LD_DERATE_PER_C);
        if (drop >= `LD_FULL_PERMILLE) begin
            return 10'h000;
        end
        return 10'(`LD_FULL_PERMILLE - drop);
    endfunction : derateLimit

    // ************************************************************
    // Enable decoding
    // ************************************************************
    // Mismatched main enables count as low; the pair is meant to be tied
    wire logic mainLine = main_enable_a & main_enable_b;
    wire logic allLow = !main_enable_a && !main_enable_b && !flash_enable;
    wire logic stop = shutdown || thermalOff;
    wire logic tsdTrip = dieTemp >= `LD_TSD_ON_C;
    wire logic tsdCool = dieTemp <= (`LD_TSD_ON_C - `LD_TSD_HYST_C);

    pulse_dim_channel #(
        .MIN_CYC(`LD_PULSE_MIN_CYC),
        .MAX_CYC(PULSE_MAX_CYC)
    ) u_main (
        .clk(clk),
        .rst(rst),
        .line(mainLine),
        .clear(shutdown),
        .grp(mainGroup)
    );

    pulse_dim_channel #(
        .MIN_CYC(`LD_PULSE_MIN_CYC),
        .MAX_CYC(PULSE_MAX_CYC)
    ) u_flash (
        .clk(clk),
        .rst(rst),
        .line(flash_enable),
        .clear(shutdown),
        .grp(flashGroup)
    );

    // ************************************************************
    // Shutdown timer
    // ************************************************************
    logic [19:0] lowCnt;

    always_ff @(posedge clk) begin
        if (rst || !allLow) begin
            lowCnt <= 20'h00000;
        end else if (lowCnt != SHDN_C) begin
            lowCnt <= lowCnt + 20'h00001;
        end
    end

    // Powers up shut down; any enable high wakes it
    always_ff @(posedge clk) begin
        if (rst) begin
            shutdown <= 1'b1;
            isolate <= 1'b1;
            outPulldown <= 1'b1;
        end else if (!allLow) begin
            shutdown <= 1'b0;
            isolate <= 1'b0;
            outPulldown <= 1'b0;
        end else if (lowCnt >= SHDN_C - 20'h00001) begin
            shutdown <= 1'b1;
            isolate <= 1'b1;
            outPulldown <= 1'b1;
        end
    end

    // ************************************************************
    // Thermal protection and LED current
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            thermalOff <= 1'b0;
        end else if (tsdTrip) begin
            thermalOff <= 1'b1;
        end else if (tsdCool) begin
            thermalOff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mainLevel <= 6'h00;
            flashLevel <= 6'h00;
            currentLimit <= 10'(`LD_FULL_PERMILLE);
        end else begin
            mainLevel <= levelOf(mainGroup, thermalOff);
            flashLevel <= levelOf(flashGroup, thermalOff);
            currentLimit <= derateLimit(dieTemp);
        end
    end

    // ************************************************************
    // Charge-pump sequencing
    // ************************************************************
    led_dim_pkg::pump_state_t next_pumpState;
    led_dim_pkg::ratio_t next_ratio;

    // Ratio picked when precharge completes
    wire led_dim_pkg::ratio_t startRatio = sense.inAboveOut
        ? led_dim_pkg::RATIO_1X
        : (sense.inAboveTwoThirds ? led_dim_pkg::RATIO_1P5X
                                  : led_dim_pkg::RATIO_2X);

    always_comb begin
        next_pumpState = pumpState;
        next_ratio = ratio;
        case (pumpState)
            led_dim_pkg::PUMP_OFF: begin
                next_ratio = led_dim_pkg::RATIO_1X;
                if (!stop) begin
                    next_pumpState = led_dim_pkg::PUMP_PRECHARGE;
                end
            end
            led_dim_pkg::PUMP_PRECHARGE: begin
                if (sense.outPrecharged) begin
                    next_ratio = startRatio;
                    if (startRatio == led_dim_pkg::RATIO_1X) begin
                        next_pumpState = led_dim_pkg::PUMP_RUN;
                    end else begin
                        next_pumpState = led_dim_pkg::PUMP_SOFT;
                    end
                end
            end
            led_dim_pkg::PUMP_SOFT: begin
                if (sense.feedbackRegulated) begin
                    next_pumpState = led_dim_pkg::PUMP_RUN;
                end
            end
            led_dim_pkg::PUMP_RUN: begin
                case (ratio)
                    led_dim_pkg::RATIO_1X: begin
                        if (sense.minFeedbackLow) begin
                            next_ratio = led_dim_pkg::RATIO_1P5X;
                        end
                    end
                    led_dim_pkg::RATIO_1P5X: begin
                        // Falling headroom wins over the step back down
                        if (sense.minFeedbackLow) begin
                            next_ratio = led_dim_pkg::RATIO_2X;
                        end else if (sense.inAboveOut) begin
                            next_ratio = led_dim_pkg::RATIO_1X;
                        end
                    end
                    led_dim_pkg::RATIO_2X: begin
                        if (sense.inAboveTwoThirds && !sense.minFeedbackLow) begin
                            next_ratio = led_dim_pkg::RATIO_1P5X;
                        end
                    end
                    default: begin
                        next_ratio = led_dim_pkg::RATIO_1X;
                    end
                endcase
            end
            default: begin
                next_pumpState = led_dim_pkg::PUMP_OFF;
            end
        endcase
        if (stop) begin
            next_pumpState = led_dim_pkg::PUMP_OFF;
            next_ratio = led_dim_pkg::RATIO_1X;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pumpState <= led_dim_pkg::PUMP_OFF;
            ratio <= led_dim_pkg::RATIO_1X;
            softStart <= 1'b0;
        end else begin
            pumpState <= next_pumpState;
            ratio <= next_ratio;
            softStart <= next_pumpState == led_dim_pkg::PUMP_PRECHARGE
                      || next_pumpState == led_dim_pkg::PUMP_SOFT;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [19:0] lowSeen;

    always_ff @(posedge clk) begin
        if (rst || !allLow) begin
            lowSeen <= 20'h00000;
        end else if (lowSeen != SHDN_C) begin
            lowSeen <= lowSeen + 20'h00001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_shdn_entry: assert property ($rose(shutdown) |-> lowSeen >= SHDN_C - 20'h00001)
        else $error("shutdown entered before the low time elapsed");
    a_shdn_exit: assert property (!allLow |=> !shutdown && !outPulldown)
        else $error("shutdown held with an enable high");
    a_main_zero: assert property (!mainLine ##1 !mainGroup.on |=> mainLevel == 6'h00)
        else $error("main current not zero while disabled");
    a_main_full: assert property ($rose(mainGroup.on) && !thermalOff
        |=> mainLevel == `LD_FULL_LEVEL)
        else $error("main group not at full brightness on enable");
    a_min_level: assert property (mainGroup.on && mainGroup.step == 5'h1F
        && !thermalOff |=> mainLevel == 6'h01)
        else $error("31st step not at minimum level");
    a_flash_follow: assert property (flash_enable && !shutdown
        && flashGroup.on == 1'b0 |=> flashGroup.on)
        else $error("flash group not enabled by its line");
    a_ratio_up1: assert property (pumpState == led_dim_pkg::PUMP_RUN
        && ratio == led_dim_pkg::RATIO_1X && sense.minFeedbackLow && !stop
        |=> ratio == led_dim_pkg::RATIO_1P5X)
        else $error("1x did not step up on low headroom");
    a_ratio_back1: assert property (pumpState == led_dim_pkg::PUMP_RUN
        && ratio == led_dim_pkg::RATIO_1P5X && !sense.minFeedbackLow
        && sense.inAboveOut && !stop |=> ratio == led_dim_pkg::RATIO_1X)
        else $error("1.5x did not return to 1x");
    a_ratio_up2: assert property (pumpState == led_dim_pkg::PUMP_RUN
        && ratio == led_dim_pkg::RATIO_1P5X && sense.minFeedbackLow && !stop
        |=> ratio == led_dim_pkg::RATIO_2X)
        else $error("1.5x did not step up on low headroom");
    a_ratio_back2: assert property (pumpState == led_dim_pkg::PUMP_RUN
        && ratio == led_dim_pkg::RATIO_2X && !sense.minFeedbackLow
        && sense.inAboveTwoThirds && !stop
        |=> ratio == led_dim_pkg::RATIO_1P5X)
        else $error("2x did not return to 1.5x");
    a_soft_1x: assert property (pumpState == led_dim_pkg::PUMP_PRECHARGE
        && sense.outPrecharged && sense.inAboveOut && !stop
        |=> !softStart && pumpState == led_dim_pkg::PUMP_RUN)
        else $error("soft-start not ended on a 1x start");
    a_soft_hold: assert property (pumpState == led_dim_pkg::PUMP_SOFT
        && !sense.feedbackRegulated && !stop |=> softStart)
        else $error("soft-start ended before regulation");
    a_derate_41: assert property (dieTemp == 9'sh029
        |=> currentLimit == 10'h3D7)
        else $error("derating at 41C is not 98.3 percent");
    a_tsd_trip: assert property (tsdTrip |=> thermalOff
        ##1 pumpState == led_dim_pkg::PUMP_OFF)
        else $error("thermal shutdown did not stop the pump");
    a_tsd_hold: assert property (thermalOff && !tsdCool |=> thermalOff)
        else $error("thermal shutdown released before cooling");

endmodule : led_pulse_dimming_control
`default_nettype wire

/* test/host_enable_model.sv */
// Host model driving the enable and dimming lines
`timescale 1ns/1ps
`default_nettype none

module host_enable_model (
    input wire logic clk,
    output var logic mainA,
    output var logic mainB,
    output var logic flashLine
);
    initial begin
        mainA = 1'b0;
        mainB = 1'b0;
        flashLine = 1'b0;
    end

    // Push-pull lines, so every level is driven just after an edge
    task automatic drive(input logic a, input logic b, input logic f);
        @(posedge clk);
        mainA <= a;
        mainB <= b;
        flashLine <= f;
    endtask : drive

    // Low for lowCyc sampled cycles, then high for two
    task automatic dim(input logic onFlash, input int lowCyc);
        @(posedge clk);
        if (onFlash) begin
            flashLine <= 1'b0;
        end else begin
            mainA <= 1'b0;
            mainB <= 1'b0;
        end
        repeat (lowCyc) @(posedge clk);
        if (onFlash) begin
            flashLine <= 1'b1;
        end else begin
            mainA <= 1'b1;
            mainB <= 1'b1;
        end
        repeat (2) @(posedge clk);
    endtask : dim
endmodule : host_enable_model

`default_nettype wire

/* test/led_pulse_dimming_control_bench.sv */
// Self-checking bench for the LED pulse-dimming control block
`timescale 1ns/1ps
`default_nettype none

module led_pulse_dimming_control_bench;
    logic clk;
    logic rst;
    logic mainA;
    logic mainB;
    logic flashLine;
    led_dim_pkg::sense_t senseIn;
    logic signed [8:0] dieTemp;
    led_dim_pkg::group_t mainGroup;
    led_dim_pkg::group_t flashGroup;
    logic [5:0] mainLevel;
    logic [5:0] flashLevel;
    logic [9:0] currentLimit;
    led_dim_pkg::ratio_t ratio;
    led_dim_pkg::pump_state_t pumpState;
    logic softStart;
    logic shutdown;
    logic isolate;
    logic outPulldown;
    logic thermalOff;
    int n_errors = 0;
    int n_tests = 0;

    // Short counts keep the run brief
    led_pulse_dimming_control #(.PULSE_MAX_CYC(200), .SHDN_CYC(300)) uut (
        .clk(clk), .rst(rst), .main_enable_a(mainA), .main_enable_b(mainB),
        .flash_enable(flashLine), .sense(senseIn), .dieTemp(dieTemp),
        .mainGroup(mainGroup), .flashGroup(flashGroup),
        .mainLevel(mainLevel), .flashLevel(flashLevel),
        .currentLimit(currentLimit), .ratio(ratio), .pumpState(pumpState),
        .softStart(softStart), .shutdown(shutdown), .isolate(isolate),
        .outPulldown(outPulldown), .thermalOff(thermalOff)
    );

    host_enable_model host (
        .clk(clk), .mainA(mainA), .mainB(mainB), .flashLine(flashLine)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Sample one step after the edge so its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic setSense(input logic [4:0] s);
        @(posedge clk);
        senseIn <= s;
    endtask : setSense

    task automatic setTemp(input logic signed [8:0] t);
        @(posedge clk);
        dieTemp <= t;
    endtask : setTemp

    task automatic finish_test;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset;
        tick(1);
        check(16'(shutdown & isolate & outPulldown), 16'h0001);
        check(16'(mainLevel), 16'h0000);
        check(16'(currentLimit), 16'h03E8);
        check(16'({ratio, pumpState}), 16'h0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_dimming;
        host.drive(1'b1, 1'b1, 1'b0);
        tick(5);
        check(16'(mainGroup), 16'h0020);
        check(16'(mainLevel), 16'h0020);
        check(16'(flashLevel), 16'h0000);
        host.dim(1'b0, 63);
        tick(2);
        check(16'(mainLevel), 16'h001F);
        host.dim(1'b0, 62);
        tick(2);
        check(16'(mainGroup), 16'h0021);
        host.dim(1'b0, 200);
        tick(2);
        check(16'(mainGroup), 16'h0022);
        repeat (29) host.dim(1'b0, 63);
        tick(2);
        check(16'(mainGroup), 16'h003F);
        check(16'(mainLevel), 16'h0001);
        host.dim(1'b0, 63);
        tick(2);
        check(16'(mainGroup), 16'h0020);
        check(16'(mainLevel), 16'h0020);
        $display("test_dimming done");
    endtask : test_dimming

    task automatic test_flash_shutdown;
        host.drive(1'b1, 1'b1, 1'b1);
        tick(5);
        check(16'(flashLevel), 16'h0020);
        host.dim(1'b1, 63);
        tick(2);
        check(16'({flashGroup, mainGroup}), 16'h0860);
        host.drive(1'b0, 1'b0, 1'b1);
        tick(210);
        check(16'({mainGroup, mainLevel}), 16'h0000);
        check(16'(flashLevel), 16'h001F);
        host.drive(1'b0, 1'b0, 1'b0);
        tick(210);
        check(16'(flashLevel), 16'h0000);
        check(16'(shutdown), 16'h0000);
        tick(95);
        check(16'({shutdown, isolate, outPulldown}), 16'h0007);
        $display("test_flash_shutdown done");
    endtask : test_flash_shutdown

    task automatic test_pump;
        host.drive(1'b1, 1'b1, 1'b0);
        tick(4);
        check(16'({pumpState, softStart}), 16'h0003);
        setSense(5'h0A);
        tick(3);
        check(16'({pumpState, ratio, softStart}), 16'h0010);
        setSense(5'h12);
        setSense(5'h02);
        tick(2);
        check(16'(ratio), 16'h0001);
        setSense(5'h12);
        setSense(5'h02);
        tick(2);
        check(16'(ratio), 16'h0003);
        setSense(5'h06);
        setSense(5'h02);
        tick(2);
        check(16'(ratio), 16'h0001);
        setSense(5'h0A);
        setSense(5'h02);
        tick(2);
        check(16'(ratio), 16'h0000);
        host.drive(1'b0, 1'b0, 1'b0);
        setSense(5'h10);
        tick(310);
        check(16'({shutdown, pumpState, ratio}), 16'h0010);
        host.drive(1'b1, 1'b1, 1'b0);
        tick(4);
        setSense(5'h12);
        tick(3);
        check(16'({pumpState, softStart}), 16'h0007);
        check(16'(ratio), 16'h0003);
        tick(5);
        check(16'(pumpState), 16'h0003);
        setSense(5'h03);
        tick(3);
        check(16'({pumpState, softStart}), 16'h0004);
        $display("test_pump done");
    endtask : test_pump

    task automatic test_thermal;
        setTemp(9'sh028);
        tick(3);
        check(16'(currentLimit), 16'h03E8);
        setTemp(9'sh029);
        tick(3);
        check(16'(currentLimit), 16'h03D7);
        setTemp(9'sh03C);
        tick(3);
        check(16'(currentLimit), 16'h0294);
        setTemp(9'sh064);
        tick(3);
        check(16'(currentLimit), 16'h0000);
        setTemp(9'sh0A0);
        tick(3);
        check(16'({thermalOff, mainLevel}), 16'h0040);
        setTemp(9'sh08D);
        tick(3);
        check(16'(thermalOff), 16'h0001);
        setTemp(9'sh08C);
        tick(3);
        check(16'(thermalOff), 16'h0000);
        $display("test_thermal done");
    endtask : test_thermal

    // ****************************************
    // Clock, reset, sequence and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        senseIn = 5'h00;
        dieTemp = 9'sh019;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_dimming();
        test_flash_shutdown();
        test_pump();
        test_thermal();
        finish_test();
    end

    // Whole run is near 3300 cycles; allow several times that
    initial begin
        #300000;
        n_errors++;
        finish_test();
    end
endmodule : led_pulse_dimming_control_bench

`default_nettype wire
